// File: aspm_uart.sv
// Asynchronous serial port with 8/9-bit frames, multiprocessor filter and baud timer
//
// Operation
// (R1) Data buffer writes load transmitter; reads return receive buffer only.
// (R2) Receive shifter is separate from buffer, so next frame shifts in early.
// (R3) Interrupt request, when enabled, follows transmit-done or receive-done flags.
// (R4) Done flags are cleared only by software writing the control register.
// (R5) Transmit clock from counter low byte; receive clock from hidden copy.
// (R6) Each counter's overflows are halved to give its bit rate.
// (R7) Overflow rate is timer clock over 256 minus reload byte.
// (R8) Receive copy shares reload and run; start edge forces its reload.
// (R9) Timer clock picks core clock, /4, /12, /48, oscillator /8, or pin.
// (R10) Control bit 7 selects 8-bit or 9-bit frames.
// (R11) 8-bit frame: start, eight data bits LSB first, stop.
// (R12) 8-bit receive stores data in buffer and stop bit in ninth field.
// (R13) Buffer write starts sending; transmit-done sets when stop bit begins.
// (R14) Receiver accepts frames only while receive enable bit is set.
// (R15) 8-bit accept needs done flag clear and, when filtering, stop bit one.
// (R16) On overrun the buffer keeps old byte; new data is dropped.
// (R17) 9-bit frame: start, eight data bits LSB first, ninth bit, stop.
// (R18) Transmitted ninth bit comes from transmit ninth bit field.
// (R19) 9-bit receive stores ninth bit; stop bit value is ignored.
// (R20) 9-bit accept needs done flag clear and, when filtering, ninth bit one.
// (R21) Master sends addresses with ninth bit one, data with zero.
// (R22) One bit per two overflows; receiver samples mid-bit from forced reload.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/100ps
`include "aspm_params.svh"

module aspm_uart (
    input  wire logic                    CLK,
    input  wire logic                    RST,
    input  wire logic [`ASPM_ADDR_W-1:0] REG_ADDR,
    input  wire logic [7:0]              REG_WDATA,
    input  wire logic                    REG_WR,
    input  wire logic                    REG_RD,
    output logic      [7:0]              REG_RDATA,
    input  wire logic                    SERIAL_IN_PIN,
    output logic                         SERIAL_OUT_PIN,
    input  wire logic                    EXT_OSC_IN,
    input  wire logic                    TIMER_EXT_INPUT,
    output logic                         IRQ
);

    aspm_pkg::aspm_core_t st_ff;
    aspm_pkg::aspm_core_t nxt_st;

    logic       tick;
    logic       start_det;
    logic       tx_ovf;
    logic       rx_ovf;
    logic [7:0] tx_cnt;
    logic       wr_ctrl;
    logic       wr_data;
    logic       wr_count;
    logic       osc_rise;
    logic       ext_rise;

    // ------------------------------------------------------------
    // Decodes shared by the counters and the state update
    // ------------------------------------------------------------
    assign wr_ctrl   = REG_WR && (REG_ADDR == `ASPM_OFF_CTRL);
    assign wr_data   = REG_WR && (REG_ADDR == `ASPM_OFF_DATA);
    assign wr_count  = REG_WR && (REG_ADDR == `ASPM_OFF_COUNT);
    assign osc_rise  = st_ff.osc_s2 && !st_ff.osc_s3;
    assign ext_rise  = st_ff.ext_s2 && !st_ff.ext_s3;
    // Falling edge on the line while idle and enabled is a start
    assign start_det = (st_ff.rx_st == aspm_pkg::RX_IDLE) && st_ff.ren
                       && st_ff.rx_s3 && !st_ff.rx_s2;              // (R14)

    // ------------------------------------------------------------
    // Timer clock source
    // ------------------------------------------------------------
    always_comb begin
        case (st_ff.sel)                                           // (R9)
            `ASPM_SEL_CORE:  tick = 1'b1;
            `ASPM_SEL_DIV4:  tick = (st_ff.pre[1:0] == `ASPM_DIV4_LOW);
            `ASPM_SEL_DIV12: tick = (st_ff.pre == `ASPM_DIV12_TOP);
            `ASPM_SEL_DIV48: tick = (st_ff.pre == `ASPM_DIV12_TOP)
                                    && (st_ff.pre_q == `ASPM_DIV48_TOP);
            `ASPM_SEL_OSC8:  tick = osc_rise && (st_ff.osc_cnt == `ASPM_OSC8_TOP);
            `ASPM_SEL_EXT:   tick = ext_rise;
            default:         tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Bit-rate counters: visible transmit one and hidden receive copy
    // ------------------------------------------------------------
    aspm_baud_ctr u_tx_ctr (                                       // (R5)
        .clk      (CLK),
        .rst      (RST),
        .tick     (tick),
        .run      (st_ff.run),
        .force_ld (1'b0),
        .sw_ld    (wr_count),
        .reload   (st_ff.reload),                                  // (R7)
        .sw_val   (REG_WDATA),
        .cnt      (tx_cnt),
        .ovf      (tx_ovf)
    );

    // The copy has no software load and no readback port
    aspm_baud_ctr u_rx_ctr (                                       // (R8)
        .clk      (CLK),
        .rst      (RST),
        .tick     (tick),
        .run      (st_ff.run),
        .force_ld (start_det),                                     // (R8)
        .sw_ld    (1'b0),
        .reload   (st_ff.reload),
        .sw_val   (`ASPM_COUNT_RST),
        .cnt      (),
        .ovf      (rx_ovf)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic set_ti;
        logic set_ri;
        logic frame_bit;
        logic tx_tick;
        logic rx_tick;
        set_ti    = 1'b0;
        set_ri    = 1'b0;
        frame_bit = 1'b0;
        tx_tick   = 1'b0;
        rx_tick   = 1'b0;
        nxt_st    = st_ff;

        // Pin synchronisers; the second and third stages feed logic
        nxt_st.rx_s1  = SERIAL_IN_PIN;
        nxt_st.rx_s2  = st_ff.rx_s1;
        nxt_st.rx_s3  = st_ff.rx_s2;
        nxt_st.osc_s1 = EXT_OSC_IN;
        nxt_st.osc_s2 = st_ff.osc_s1;
        nxt_st.osc_s3 = st_ff.osc_s2;
        nxt_st.ext_s1 = TIMER_EXT_INPUT;
        nxt_st.ext_s2 = st_ff.ext_s1;
        nxt_st.ext_s3 = st_ff.ext_s2;

        // Prescalers run always so a source switch takes effect at once
        if (st_ff.pre == `ASPM_DIV12_TOP) begin
            nxt_st.pre   = 4'h0;
            nxt_st.pre_q = st_ff.pre_q + 2'h1;
        end else begin
            nxt_st.pre = st_ff.pre + 4'h1;
        end
        if (osc_rise) begin
            nxt_st.osc_cnt = st_ff.osc_cnt + 3'h1;
        end

        // ---- Transmitter ----
        if (tx_ovf) begin
            nxt_st.tx_half = !st_ff.tx_half;                       // (R6)
            tx_tick        = st_ff.tx_half;                        // (R22)
        end
        if (wr_data) begin
            // A write mid-frame restarts with the new byte
            nxt_st.tx_sh  = REG_WDATA;                             // (R1)
            nxt_st.tx_st  = aspm_pkg::TX_WAIT;                     // (R13)
        end else if (tx_tick) begin
            case (st_ff.tx_st)
                aspm_pkg::TX_WAIT: begin
                    nxt_st.tx_out = 1'b0;
                    nxt_st.tx_st  = aspm_pkg::TX_START;
                end
                aspm_pkg::TX_START: begin
                    nxt_st.tx_out = st_ff.tx_sh[0];                // (R11)
                    nxt_st.tx_sh  = {1'b0, st_ff.tx_sh[7:1]};
                    nxt_st.tx_bit = 4'h1;
                    nxt_st.tx_st  = aspm_pkg::TX_DATA;
                end
                aspm_pkg::TX_DATA: begin
                    if (st_ff.tx_bit == `ASPM_DATA_BITS) begin
                        if (st_ff.mode) begin                      // (R10)
                            nxt_st.tx_out = st_ff.tb8;             // (R18)
                            nxt_st.tx_st  = aspm_pkg::TX_NINTH;    // (R17)
                        end else begin
                            nxt_st.tx_out = 1'b1;
                            nxt_st.tx_st  = aspm_pkg::TX_STOP;
                            set_ti        = 1'b1;                  // (R13)
                        end
                    end else begin
                        nxt_st.tx_out = st_ff.tx_sh[0];
                        nxt_st.tx_sh  = {1'b0, st_ff.tx_sh[7:1]};
                        nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
                    end
                end
                aspm_pkg::TX_NINTH: begin
                    nxt_st.tx_out = 1'b1;
                    nxt_st.tx_st  = aspm_pkg::TX_STOP;
                    set_ti        = 1'b1;                          // (R13)
                end
                aspm_pkg::TX_STOP: begin
                    nxt_st.tx_st = aspm_pkg::TX_IDLE;
                end
                default: begin
                    nxt_st.tx_out = 1'b1;
                end
            endcase
        end

        // ---- Receiver ----
        if (start_det) begin
            nxt_st.rx_st    = aspm_pkg::RX_START;
            nxt_st.rx_phase = 1'b0;                                // (R22)
        end else if (rx_ovf) begin
            // First overflow after the forced reload is mid start bit
            nxt_st.rx_phase = !st_ff.rx_phase;                     // (R6)
            rx_tick         = !st_ff.rx_phase;                     // (R22)
        end
        if (rx_tick) begin
            case (st_ff.rx_st)
                aspm_pkg::RX_START: begin
                    // A high line at mid start bit was a glitch
                    nxt_st.rx_st  = st_ff.rx_s2 ? aspm_pkg::RX_IDLE : aspm_pkg::RX_DATA;
                    nxt_st.rx_bit = 4'h0;
                end
                aspm_pkg::RX_DATA: begin
                    nxt_st.rx_sh  = {st_ff.rx_s2, st_ff.rx_sh[7:1]};  // (R2)
                    nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
                    if ((st_ff.rx_bit + 4'h1) == `ASPM_DATA_BITS) begin
                        nxt_st.rx_st = st_ff.mode ? aspm_pkg::RX_NINTH
                                                  : aspm_pkg::RX_STOP;  // (R10)
                    end
                end
                aspm_pkg::RX_NINTH: begin
                    nxt_st.rx_n9 = st_ff.rx_s2;
                    nxt_st.rx_st = aspm_pkg::RX_STOP;
                end
                aspm_pkg::RX_STOP: begin
                    // Nine-bit frames ignore the stop level
                    frame_bit    = st_ff.mode ? st_ff.rx_n9 : st_ff.rx_s2;  // (R19)
                    nxt_st.rx_st = aspm_pkg::RX_IDLE;
                    if (!st_ff.ri && (!st_ff.mce || frame_bit)) begin   // (R15) (R20)
                        nxt_st.rx_buf = st_ff.rx_sh;               // (R12)
                        set_ri        = 1'b1;
                    end                                            // (R16)
                end
                default: begin
                    nxt_st.rx_st = aspm_pkg::RX_IDLE;
                end
            endcase
        end

        // ---- Register writes ----
        if (wr_ctrl) begin
            nxt_st.mode = REG_WDATA[`ASPM_CTRL_MODE];
            nxt_st.mce  = REG_WDATA[`ASPM_CTRL_MCE];
            nxt_st.ren  = REG_WDATA[`ASPM_CTRL_REN];
            nxt_st.tb8  = REG_WDATA[`ASPM_CTRL_TB8];
            nxt_st.rb8  = REG_WDATA[`ASPM_CTRL_RB8];
            nxt_st.ti   = REG_WDATA[`ASPM_CTRL_TI];                // (R4)
            nxt_st.ri   = REG_WDATA[`ASPM_CTRL_RI];                // (R4)
        end
        if (REG_WR && (REG_ADDR == `ASPM_OFF_RELOAD)) begin
            nxt_st.reload = REG_WDATA;
        end
        if (REG_WR && (REG_ADDR == `ASPM_OFF_TIMER)) begin
            nxt_st.run    = REG_WDATA[`ASPM_TMR_RUN];
            nxt_st.sel    = REG_WDATA[`ASPM_TMR_SEL_HI:`ASPM_TMR_SEL_LO];
            nxt_st.irq_en = REG_WDATA[`ASPM_TMR_IRQ_EN];
        end
        // Hardware events win over a same-cycle software clear
        if (set_ti) begin
            nxt_st.ti = 1'b1;
        end
        if (set_ri) begin
            nxt_st.ri  = 1'b1;
            nxt_st.rb8 = frame_bit;                                // (R12) (R19)
        end

        // ---- Register reads, valid one cycle after the strobe ----
        nxt_st.rdata = 8'h00;
        if (REG_RD) begin
            if (REG_ADDR == `ASPM_OFF_CTRL) begin
                nxt_st.rdata = {st_ff.mode, 1'b1, st_ff.mce, st_ff.ren,
                                st_ff.tb8, st_ff.rb8, st_ff.ti, st_ff.ri};
            end else if (REG_ADDR == `ASPM_OFF_DATA) begin
                nxt_st.rdata = st_ff.rx_buf;                       // (R1)
            end else if (REG_ADDR == `ASPM_OFF_RELOAD) begin
                nxt_st.rdata = st_ff.reload;
            end else if (REG_ADDR == `ASPM_OFF_COUNT) begin
                nxt_st.rdata = tx_cnt;
            end else if (REG_ADDR == `ASPM_OFF_TIMER) begin
                nxt_st.rdata = {3'h0, st_ff.irq_en, st_ff.sel, st_ff.run};
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_ff          <= '0;
            st_ff.mode     <= 1'(`ASPM_CTRL_RST >> `ASPM_CTRL_MODE);
            st_ff.reload   <= `ASPM_RELOAD_RST;
            st_ff.rx_s1    <= 1'b1;
            st_ff.rx_s2    <= 1'b1;
            st_ff.rx_s3    <= 1'b1;
            st_ff.tx_st    <= aspm_pkg::TX_IDLE;
            st_ff.tx_out   <= 1'b1;
            st_ff.rx_st    <= aspm_pkg::RX_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign REG_RDATA      = st_ff.rdata;
    assign SERIAL_OUT_PIN = st_ff.tx_out;
    assign IRQ            = st_ff.irq_en && (st_ff.ti || st_ff.ri);  // (R3)

endmodule : aspm_uart

// File: aspm_params.svh
// Constants of the asynchronous serial port: offsets, bit positions, reset values, divider counts
`ifndef ASPM_PARAMS_SVH
`define ASPM_PARAMS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define ASPM_ADDR_W          3
`define ASPM_OFF_CTRL        3'h0
`define ASPM_OFF_DATA        3'h1
`define ASPM_OFF_RELOAD      3'h2
`define ASPM_OFF_COUNT       3'h3
`define ASPM_OFF_TIMER       3'h4

// ------------------------------------------------------------
// Field positions of serial_control_reg
// ------------------------------------------------------------
`define ASPM_CTRL_MODE       7
`define ASPM_CTRL_UNUSED     6
`define ASPM_CTRL_MCE        5
`define ASPM_CTRL_REN        4
`define ASPM_CTRL_TB8        3
`define ASPM_CTRL_RB8        2
`define ASPM_CTRL_TI         1
`define ASPM_CTRL_RI         0

// ------------------------------------------------------------
// Field positions of the timer control register
// ------------------------------------------------------------
`define ASPM_TMR_RUN         0
`define ASPM_TMR_SEL_LO      1
`define ASPM_TMR_SEL_HI      3
`define ASPM_TMR_IRQ_EN      4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ASPM_CTRL_RST        8'h40
`define ASPM_TMR_RST         8'h00
`define ASPM_RELOAD_RST      8'h00
`define ASPM_COUNT_RST       8'h00

// ------------------------------------------------------------
// Timer clock sources and divider counts
// ------------------------------------------------------------
`define ASPM_SEL_CORE        3'h0
`define ASPM_SEL_DIV4        3'h1
`define ASPM_SEL_DIV12       3'h2
`define ASPM_SEL_DIV48       3'h3
`define ASPM_SEL_OSC8        3'h4
`define ASPM_SEL_EXT         3'h5
`define ASPM_DIV12_TOP       4'hB
`define ASPM_DIV4_LOW        2'h3
`define ASPM_DIV48_TOP       2'h3
`define ASPM_OSC8_TOP        3'h7

// ------------------------------------------------------------
// Frame and counter figures
// ------------------------------------------------------------
`define ASPM_DATA_BITS       4'h8
`define ASPM_CNT_TOP         8'hFF

`endif

// File: aspm_pkg.sv
// Types shared by the serial port modules
package aspm_pkg;

    // ------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------
    typedef enum logic [2:0] {TX_IDLE, TX_WAIT, TX_START, TX_DATA, TX_NINTH, TX_STOP} aspm_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP} aspm_rx_st_t;

    // ------------------------------------------------------------
    // Module state records
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] cnt;
        logic       ovf;
    } aspm_ctr_t;

    typedef struct packed {
        logic        mode;
        logic        mce;
        logic        ren;
        logic        tb8;
        logic        rb8;
        logic        ti;
        logic        ri;
        logic [7:0]  reload;
        logic        run;
        logic [2:0]  sel;
        logic        irq_en;
        logic [7:0]  rx_buf;
        logic [7:0]  rdata;
        logic [3:0]  pre;
        logic [1:0]  pre_q;
        logic [2:0]  osc_cnt;
        logic        rx_s1;
        logic        rx_s2;
        logic        rx_s3;
        logic        osc_s1;
        logic        osc_s2;
        logic        osc_s3;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_s3;
        aspm_tx_st_t tx_st;
        logic        tx_half;
        logic [7:0]  tx_sh;
        logic [3:0]  tx_bit;
        logic        tx_out;
        aspm_rx_st_t rx_st;
        logic        rx_phase;
        logic [7:0]  rx_sh;
        logic [3:0]  rx_bit;
        logic        rx_n9;
    } aspm_core_t;

endpackage : aspm_pkg

// File: aspm_baud_ctr.sv
// Eight-bit auto-reload bit-rate counter with forced and software reload
`timescale 1ns/100ps
`include "aspm_params.svh"

module aspm_baud_ctr (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       force_ld,
    input  wire logic       sw_ld,
    input  wire logic [7:0] reload,
    input  wire logic [7:0] sw_val,
    output logic      [7:0] cnt,
    output logic            ovf
);

    aspm_pkg::aspm_ctr_t st_ff;
    aspm_pkg::aspm_ctr_t nxt_st;

    // ------------------------------------------------------------
    // Count, wrap to the reload byte, flag one overflow pulse
    // ------------------------------------------------------------
    always_comb begin
        nxt_st     = st_ff;
        nxt_st.ovf = 1'b0;
        if (force_ld) begin
            nxt_st.cnt = reload;
        end else if (sw_ld) begin
            nxt_st.cnt = sw_val;
        end else if (run && tick) begin
            if (st_ff.cnt == `ASPM_CNT_TOP) begin
                nxt_st.cnt = reload;
                nxt_st.ovf = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{cnt: `ASPM_COUNT_RST, ovf: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cnt = st_ff.cnt;
    assign ovf = st_ff.ovf;

endmodule : aspm_baud_ctr

// File: aspm_uart_chk.sv
// Port checker for the serial port
`timescale 1ns/100ps

module aspm_uart_chk (
    input wire logic       CLK,
    input wire logic       RST,
    input wire logic [2:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic       REG_WR,
    input wire logic       REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic       SERIAL_IN_PIN,
    input wire logic       SERIAL_OUT_PIN,
    input wire logic       EXT_OSC_IN,
    input wire logic       TIMER_EXT_INPUT,
    input wire logic       IRQ
);
    // ------------------------------------------------------------
    // Shadow of software writes and line run length
    // ------------------------------------------------------------
    logic [7:0]  rl_ff;
    logic        ie_ff;
    logic        arm_ff;
    logic        prv_ff;
    logic [15:0] run_ff;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rl_ff  <= 8'h00;
            ie_ff  <= 1'b0;
            arm_ff <= 1'b0;
            prv_ff <= 1'b1;
            run_ff <= 16'h0000;
        end else begin
            if (REG_WR && REG_ADDR == 3'h2) rl_ff <= REG_WDATA;
            if (REG_WR && REG_ADDR == 3'h4) ie_ff <= REG_WDATA[4];
            if (REG_WR && REG_ADDR == 3'h1) arm_ff <= 1'b1;
            prv_ff <= SERIAL_OUT_PIN;
            // Saturates so a long idle line never wraps into a short run
            if (SERIAL_OUT_PIN != prv_ff) run_ff <= 16'h0001;
            else if (run_ff != 16'hFFFF) run_ff <= run_ff + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data not zero outside read answer");
    chk_ctrl_back: assert property ((REG_WR && REG_ADDR == 3'h0 ##1 !REG_WR ##1 REG_RD
        && REG_ADDR == 3'h0) |=> (REG_RDATA & 8'hF8) == (($past(REG_WDATA, 3) & 8'hB8) | 8'h40))
        else $error("control readback differs from written bits");
    chk_tx_quiet: assert property (!arm_ff |-> SERIAL_OUT_PIN)
        else $error("line left idle before any data write");
    chk_tx_start: assert property (REG_WR && REG_ADDR == 3'h1 |-> ##[1:600] !SERIAL_OUT_PIN)
        else $error("no start bit after data write");
    chk_bit_len: assert property ((SERIAL_OUT_PIN != prv_ff)
        |-> run_ff >= ({8'h00, ~rl_ff} + 16'h0001) * 16'h0002 - 16'h0001)
        else $error("serial bit shorter than two counter overflows");
    chk_irq_gate: assert property (!ie_ff |-> !IRQ)
        else $error("interrupt raised while disabled");
    chk_irq_flags: assert property (($past(REG_RD) && $past(REG_ADDR) == 3'h0 && $past(IRQ))
        |-> REG_RDATA[1:0] != 2'h0)
        else $error("interrupt high without a done flag");
    chk_irq_sw_clr: assert property ((ie_ff && $past(ie_ff) && $fell(IRQ))
        |-> $past(REG_WR) && $past(REG_ADDR) == 3'h0)
        else $error("done flag cleared without software write");
endmodule : aspm_uart_chk

bind aspm_uart aspm_uart_chk u_chk (.CLK(CLK), .RST(RST), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN), .EXT_OSC_IN(EXT_OSC_IN),
    .TIMER_EXT_INPUT(TIMER_EXT_INPUT), .IRQ(IRQ));

// File: aspm_peer.sv
// Far-end serial node model
`timescale 1ns/100ps

module aspm_peer #(
    parameter int BT = 65
) (
    input  wire logic clk,
    input  wire logic rx_line,
    output logic      tx_line
);
    logic [9:0] got;
    int         nfr = 0;
    initial tx_line = 1'b1;

    // Sends LSB first; nb is 8 or 9 data bits, line idles high after
    task automatic send(input logic [8:0] d, input int nb);
        logic [10:0] f;
        f = (nb == 9) ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
        for (int i = 0; i < nb + 2; i++) begin
            @(posedge clk);
            tx_line <= f[i];
            repeat (BT - 1) @(posedge clk);
        end
    endtask : send

    // Mid-bit sampling; BT sits between the possible bit lengths
    always begin
        @(negedge rx_line);
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (BT) @(posedge clk);
            got[i] = rx_line;
        end
        nfr++;
        wait (rx_line);
    end
endmodule : aspm_peer

// File: aspm_uart_test.sv
// Testbench for the serial port
`timescale 1ns/100ps

module aspm_uart_test;
    logic       clk, rst, wr, rd, sin, sout, osc, tpin, irq, iq;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v, a;
    int         failures = 0;
    int         tests_run = 0;
    int         cyc = 0;

    aspm_uart dut (.CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
        .REG_RD(rd), .REG_RDATA(rdata), .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout),
        .EXT_OSC_IN(osc), .TIMER_EXT_INPUT(tpin), .IRQ(irq));
    aspm_peer #(.BT(65)) peer (.clk(clk), .rx_line(sout), .tx_line(sin));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always #130 osc = ~osc;
    always #310 tpin = ~tpin;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wrr(input logic [2:0] ad, input logic [7:0] d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wrr
    task automatic rdr(input logic [2:0] ad);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 {v, iq} = {rdata, irq};
        @(posedge clk);
    endtask : rdr
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [2:0] ads [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7};
        wrr(3'h7, 8'hFF);
        foreach (ads[i]) begin
            rdr(ads[i]);
            chk(v, (i == 0) ? 8'h40 : 8'h00);
        end
        wrr(3'h0, 8'hB8);
        rdr(3'h0);
        chk(v, 8'hF8);
        $display("test regs done");
    endtask : t_regs
    task automatic t_tx;
        logic [7:0] cfg [3] = '{8'h00, 8'h80, 8'h88};
        int n;
        foreach (cfg[k]) begin
            wrr(3'h0, cfg[k]);
            n = peer.nfr;
            wrr(3'h1, 8'hA5 ^ 8'(k));
            for (int i = 0; i < 2000 && peer.nfr == n; i++) @(posedge clk);
            chk(peer.got[7:0], 8'hA5 ^ 8'(k));
            chk({6'h0, peer.got[9:8]}, (k == 1) ? 8'h02 : 8'h03);
            rdr(3'h0);
            chk(v & 8'h02, 8'h02);
            chk({7'h0, iq}, 8'h01);
            rdr(3'h1);
            chk(v, 8'h00);
            wrr(3'h0, cfg[k]);
            rdr(3'h0);
            chk({7'h0, iq}, 8'h00);
        end
        $display("test tx done");
    endtask : t_tx
    task automatic t_rx;
        peer.send(9'h05A, 8);
        rdr(3'h0);
        chk(v & 8'h01, 8'h00);
        wrr(3'h0, 8'h10);
        peer.send(9'h05A, 8);
        rdr(3'h0);
        chk(v & 8'h05, 8'h05);
        chk({7'h0, iq}, 8'h01);
        peer.send(9'h077, 8);
        rdr(3'h1);
        chk(v, 8'h5A);
        wrr(3'h0, 8'h30);
        peer.send(9'h044, 9);
        rdr(3'h0);
        chk(v & 8'h01, 8'h00);
        wrr(3'h0, 8'hB0);
        peer.send(9'h011, 9);
        rdr(3'h0);
        chk(v & 8'h01, 8'h00);
        peer.send(9'h122, 9);
        rdr(3'h1);
        chk(v, 8'h22);
        wrr(3'h0, 8'h90);
        peer.send(9'h033, 9);
        rdr(3'h0);
        chk(v & 8'h05, 8'h01);
        rdr(3'h1);
        chk(v, 8'h33);
        $display("test rx done");
    endtask : t_rx
    task automatic t_src;
        for (int s = 0; s < 7; s++) begin
            wrr(3'h4, {4'h1, 3'(s), 1'b1});
            rdr(3'h3);
            a = v;
            repeat (200) @(posedge clk);
            rdr(3'h3);
            chk({7'h0, a != v}, (s < 6) ? 8'h01 : 8'h00);
        end
        $display("test sources done");
    endtask : t_src

    always @(posedge clk) begin
        if (++cyc == 30000) begin
            failures++;
            results();
        end
    end

    initial begin
        {rst, wr, rd, osc, tpin, addr, wdata} = 16'h8000;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        wrr(3'h2, 8'hE0);
        wrr(3'h4, 8'h11);
        t_tx();
        t_rx();
        t_src();
        results();
    end
endmodule : aspm_uart_test
